/* core/dmv_defs.vh */
// Register map, field positions, reset values and codes of the mode and volume block
`ifndef DMV_DEFS_VH
`define DMV_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMV_OFS_PROGRAM_MODE_AND_HIZ  8'h40
`define DMV_OFS_PROCESSING_CONTROL    8'h46
`define DMV_OFS_DIGITAL_VOLUME        8'h4C
`define DMV_OFS_VOLUME_RAMP_CONTROL   8'h4E

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMV_RST_PROGRAM_MODE_AND_HIZ  8'h01
`define DMV_RST_PROCESSING_CONTROL    8'h01
`define DMV_RST_DIGITAL_VOLUME        8'h30
`define DMV_RST_VOLUME_RAMP_CONTROL   8'h33

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMV_BIT_LEFT_FORCE_HIGHZ      3
`define DMV_BIT_RIGHT_FORCE_HIGHZ     2
`define DMV_BIT_BUILTIN_COEF_SELECT   0
`define DMV_CTRL_READ_ZERO_MASK       8'hF9
`define DMV_RATE_INSTANT              2'h3

// ----------------------------------------------------------------
// Volume codes and step sizes in half-dB codes
// ----------------------------------------------------------------
`define DMV_VOLUME_MUTE               8'hFF
`define DMV_STEP_4DB                  8'h08
`define DMV_STEP_2DB                  8'h04
`define DMV_STEP_1DB                  8'h02
`define DMV_STEP_HALF_DB              8'h01

// ----------------------------------------------------------------
// Serial control port
// ----------------------------------------------------------------
`define DMV_I2C_DEVICE_ADDR           7'h2C
`define DMV_UNMAPPED_READ             8'h00

`endif

/* core/dmv_i2c_slave.v */
// Serial control port slave: byte engine with sub-address and auto-increment
`timescale 1ns/1ps
`default_nettype none
`include "dmv_defs.vh"

module dmv_i2c_slave (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_oen,
  output wire [7:0] reg_addr,
  output wire       wr_stb,
  output wire [7:0] wr_data,
  input  wire [7:0] rd_data
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       scl_prev_reg;
  reg       sda_prev_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  wire scl_s    = scl_sync_reg[1];
  wire sda_s    = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_c  = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_c   = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ----------------------------------------------------------------
  // Byte state machine
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DEV  = 5'h02;
  localparam [4:0] ST_SUB  = 5'h04;
  localparam [4:0] ST_WR   = 5'h08;
  localparam [4:0] ST_RD   = 5'h10;

  reg [4:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg       rw_reg;
  reg       oen_reg;
  reg       wr_stb_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      oen_reg     <= 1'b1;
      wr_stb_reg  <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (start_c) begin
        state_reg   <= ST_DEV;
        bit_cnt_reg <= 4'h0;
        oen_reg     <= 1'b1;
      end else if (stop_c) begin
        state_reg <= ST_IDLE;
        oen_reg   <= 1'b1;
      end else if (scl_rise) begin
        case (state_reg)
          ST_DEV, ST_SUB, ST_WR: begin
            if (bit_cnt_reg < 4'h8) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          ST_RD: begin
            if (bit_cnt_reg == 4'h8) begin
              // A not-acknowledge from the master ends the read burst
              bit_cnt_reg <= 4'h0;
              if (sda_s) begin
                state_reg <= ST_IDLE;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default: begin
            bit_cnt_reg <= bit_cnt_reg;
          end
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          ST_DEV, ST_SUB, ST_WR: begin
            if (bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h9;
              oen_reg     <= 1'b0;
              if (state_reg == ST_DEV) begin
                rw_reg <= shift_reg[0];
                if (shift_reg[7:1] != `DMV_I2C_DEVICE_ADDR) begin
                  state_reg <= ST_IDLE;
                  oen_reg   <= 1'b1;
                end
              end else if (state_reg == ST_SUB) begin
                ptr_reg <= shift_reg;
              end else begin
                wr_stb_reg <= 1'b1;
              end
            end else if (bit_cnt_reg == 4'h9) begin
              bit_cnt_reg <= 4'h0;
              oen_reg     <= 1'b1;
              if (state_reg == ST_DEV) begin
                if (rw_reg) begin
                  state_reg <= ST_RD;
                  shift_reg <= rd_data;
                  oen_reg   <= rd_data[7];
                end else begin
                  state_reg <= ST_SUB;
                end
              end else if (state_reg == ST_SUB) begin
                state_reg <= ST_WR;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (bit_cnt_reg == 4'h0) begin
              shift_reg <= rd_data;
              oen_reg   <= rd_data[7];
            end else if (bit_cnt_reg < 4'h8) begin
              oen_reg <= shift_reg[7];
            end else begin
              oen_reg <= 1'b1;
            end
          end
          default: begin
            oen_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  assign sda_oen  = oen_reg;
  assign reg_addr = ptr_reg;
  assign wr_stb   = wr_stb_reg;
  assign wr_data  = shift_reg;

endmodule

`default_nettype wire

/* core/dmv_mode_volume.v */
// Processing mode, forced high impedance and digital volume ramp registers
`timescale 1ns/1ps
`default_nettype none
`include "dmv_defs.vh"

// What this block does
// R01 - Writing one to bit 3 of the program mode register forces the left output to high-Z.
// R02 - Writing one to bit 2 of the program mode register forces the right output to high-Z.
// R03 - With its force bit clear, a channel follows the channel state of the device control.
// R04 - A forced channel is released only by writing its force bit to zero.
// R05 - Both force bits are ignored while the output stage runs in bridged mono mode.
// R06 - The program select field picks the RAM program at 00 or ROM programs 1 to 3, reset 01.
// R07 - Bit 0 of the processing control selects ROM coefficients at one, host ones at zero.
// R08 - The volume code runs from +24 dB at 00h down to -103 dB at FEh in 0.5 dB per code.
// R09 - One volume code serves both channels, 30h is unity gain and reset, FFh mutes.
// R10 - A volume decrease updates every 1, 2 or 4 sample periods for fall rate codes 00, 01, 10.
// R11 - Fall rate code 11 skips the ramp and mutes the volume at once.
// R12 - Each fall update lowers the volume by 4, 2, 1 or 0.5 dB for step codes 00 to 11, reset 11.
// R13 - A volume increase updates every 1, 2 or 4 sample periods for rise rate codes 00, 01, 10.
// R14 - Rise rate code 11 restores the target volume at once.
// R15 - Each rise update raises the volume by 4, 2, 1 or 0.5 dB for step codes 00 to 11, reset 11.
// R16 - The ramp moves from the applied volume toward the target and stops exactly on it.
module dmv_mode_volume (
  input  wire       SYS_CLK,
  input  wire       SRST,
  input  wire       SCL_I,
  input  wire       SDA_I,
  output wire       SDA_O,
  output wire       SDA_OEN,
  input  wire       FRAME_CLK,
  input  wire       BRIDGED_MONO_MODE,
  input  wire       LEFT_STATE_HIZ,
  input  wire       RIGHT_STATE_HIZ,
  output wire       LEFT_HIZ,
  output wire       RIGHT_HIZ,
  output wire [1:0] PROGRAM_SELECT,
  output wire       BUILTIN_COEF_SELECT,
  output wire [1:0] PROCESSING_RATE,
  output wire [7:0] VOLUME_CODE,
  output wire       VOLUME_MUTE,
  output wire       VOLUME_BUSY
);

  // ----------------------------------------------------------------
  // Serial control port
  // ----------------------------------------------------------------
  wire [7:0] reg_addr;
  wire       wr_stb;
  wire [7:0] wr_data;
  reg  [7:0] rd_data;

  dmv_i2c_slave u_port (
    .sys_clk  (SYS_CLK),
    .srst     (SRST),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .sda_oen  (SDA_OEN),
    .reg_addr (reg_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // Open-drain line: only ever pulled low
  assign SDA_O = 1'b0;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg [7:0] program_mode_and_hiz_reg;
  reg [7:0] processing_control_reg;
  reg [7:0] digital_volume_reg;
  reg [7:0] volume_ramp_control_reg;

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      program_mode_and_hiz_reg <= `DMV_RST_PROGRAM_MODE_AND_HIZ; // see R06
      processing_control_reg   <= `DMV_RST_PROCESSING_CONTROL;   // see R07
      digital_volume_reg       <= `DMV_RST_DIGITAL_VOLUME;       // see R09
      volume_ramp_control_reg  <= `DMV_RST_VOLUME_RAMP_CONTROL;  // see R12
    end else if (wr_stb) begin
      case (reg_addr)
        // Force bits change only through this write, see R04
        `DMV_OFS_PROGRAM_MODE_AND_HIZ: begin
          program_mode_and_hiz_reg <= wr_data;
        end
        `DMV_OFS_PROCESSING_CONTROL: begin
          processing_control_reg <= wr_data & `DMV_CTRL_READ_ZERO_MASK;
        end
        `DMV_OFS_DIGITAL_VOLUME: begin
          digital_volume_reg <= wr_data;
        end
        `DMV_OFS_VOLUME_RAMP_CONTROL: begin
          volume_ramp_control_reg <= wr_data;
        end
        default: begin
          digital_volume_reg <= digital_volume_reg;
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `DMV_OFS_PROGRAM_MODE_AND_HIZ: begin
        rd_data = program_mode_and_hiz_reg;
      end
      `DMV_OFS_PROCESSING_CONTROL: begin
        rd_data = processing_control_reg;
      end
      `DMV_OFS_DIGITAL_VOLUME: begin
        rd_data = digital_volume_reg;
      end
      `DMV_OFS_VOLUME_RAMP_CONTROL: begin
        rd_data = volume_ramp_control_reg;
      end
      default: begin
        rd_data = `DMV_UNMAPPED_READ;
      end
    endcase
  end

  wire       left_force_highz  = program_mode_and_hiz_reg[`DMV_BIT_LEFT_FORCE_HIGHZ];
  wire       right_force_highz = program_mode_and_hiz_reg[`DMV_BIT_RIGHT_FORCE_HIGHZ];
  wire [1:0] fall_update_rate  = volume_ramp_control_reg[7:6];
  wire [1:0] fall_step_size    = volume_ramp_control_reg[5:4];
  wire [1:0] rise_update_rate  = volume_ramp_control_reg[3:2];
  wire [1:0] rise_step_size    = volume_ramp_control_reg[1:0];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] frame_sync_reg;
  reg       frame_prev_reg;
  reg [1:0] mono_sync_reg;

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      frame_sync_reg <= 2'h0;
      frame_prev_reg <= 1'b0;
    end else begin
      frame_sync_reg <= {frame_sync_reg[0], FRAME_CLK};
      frame_prev_reg <= frame_sync_reg[1];
    end
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      mono_sync_reg <= 2'h0;
    end else begin
      mono_sync_reg <= {mono_sync_reg[0], BRIDGED_MONO_MODE};
    end
  end

  // One pulse per sample period, on the rising frame clock edge
  wire fs_tick           = frame_sync_reg[1] & ~frame_prev_reg;
  wire bridged_mono_mode = mono_sync_reg[1];

  // ----------------------------------------------------------------
  // Output stage state and processing selections
  // ----------------------------------------------------------------
  // Channel index 1 is left and 0 is right
  wire [1:0] force_highz = {left_force_highz, right_force_highz}; // see R01 R02
  wire [1:0] state_hiz   = {LEFT_STATE_HIZ, RIGHT_STATE_HIZ};
  reg  [1:0] chan_hiz_reg;
  reg  [1:0] program_select_reg;
  reg        builtin_coef_select_reg;
  reg  [1:0] processing_rate_reg;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      always @(posedge SYS_CLK) begin
        if (SRST) begin
          chan_hiz_reg[ch] <= 1'b0;
        end else begin
          // Mono ignores the force bits but leaves them stored, see R05
          chan_hiz_reg[ch] <= (force_highz[ch] & ~bridged_mono_mode) | state_hiz[ch]; // see R03
        end
      end
    end
  endgenerate

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      program_select_reg      <= 2'h1;
      builtin_coef_select_reg <= 1'b1;
      processing_rate_reg     <= 2'h0;
    end else begin
      program_select_reg      <= program_mode_and_hiz_reg[1:0];                   // see R06
      builtin_coef_select_reg <= processing_control_reg[`DMV_BIT_BUILTIN_COEF_SELECT]; // see R07
      processing_rate_reg     <= processing_control_reg[4:3];
    end
  end

  // ----------------------------------------------------------------
  // Volume ramp
  // ----------------------------------------------------------------
  function [7:0] step_codes;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: begin
          step_codes = `DMV_STEP_4DB;
        end
        2'h1: begin
          step_codes = `DMV_STEP_2DB;
        end
        2'h2: begin
          step_codes = `DMV_STEP_1DB;
        end
        default: begin
          step_codes = `DMV_STEP_HALF_DB;
        end
      endcase
    end
  endfunction

  reg  [7:0] applied_reg;
  reg  [1:0] period_cnt_reg;
  reg  [7:0] applied_next;
  reg  [1:0] period_cnt_next;

  // A larger code is quieter, so a falling volume is a rising code
  wire       going_down = applied_reg < digital_volume_reg;
  wire       going_up   = applied_reg > digital_volume_reg;
  wire [1:0] rate_sel   = going_down ? fall_update_rate : rise_update_rate;
  wire [7:0] step       = going_down ? step_codes(fall_step_size) : step_codes(rise_step_size);
  wire [7:0] distance   = going_down ? digital_volume_reg - applied_reg
                                     : applied_reg - digital_volume_reg;
  // Last count of the period: 1, 2 or 4 sample periods, see R10 R13
  wire [1:0] period_last = {rate_sel[1], rate_sel[1] | rate_sel[0]};

  always @* begin
    applied_next    = applied_reg;
    period_cnt_next = period_cnt_reg;
    if (!going_down && !going_up) begin
      period_cnt_next = 2'h0;
    end else if (rate_sel == `DMV_RATE_INSTANT) begin
      period_cnt_next = 2'h0;
      if (going_down) begin
        applied_next = `DMV_VOLUME_MUTE; // see R11
      end else begin
        applied_next = digital_volume_reg; // see R14
      end
    end else if (fs_tick) begin
      if (period_cnt_reg >= period_last) begin
        period_cnt_next = 2'h0;
        // Clamp on the target so a coarse step never overshoots, see R16
        if (distance <= step) begin
          applied_next = digital_volume_reg;
        end else if (going_down) begin
          applied_next = applied_reg + step; // see R12
        end else begin
          applied_next = applied_reg - step; // see R15
        end
      end else begin
        period_cnt_next = period_cnt_reg + 2'h1;
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      applied_reg    <= `DMV_RST_DIGITAL_VOLUME;
      period_cnt_reg <= 2'h0;
    end else begin
      applied_reg    <= applied_next;
      period_cnt_reg <= period_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign LEFT_HIZ            = chan_hiz_reg[1];
  assign RIGHT_HIZ           = chan_hiz_reg[0];
  assign PROGRAM_SELECT      = program_select_reg;
  assign BUILTIN_COEF_SELECT = builtin_coef_select_reg;
  assign PROCESSING_RATE     = processing_rate_reg;
  // Shared by both channels; code maps at 0.5 dB per step, see R08 R09
  assign VOLUME_CODE         = applied_reg;
  assign VOLUME_MUTE         = applied_reg == `DMV_VOLUME_MUTE; // see R09
  assign VOLUME_BUSY         = applied_reg != digital_volume_reg;

endmodule

`default_nettype wire

/* verification/dmv_mode_volume_sva.sv */
// Port-level checks of the mode and volume block
`timescale 1ns/1ps
`default_nettype none

module dmv_mode_volume_sva (
  input wire logic       SYS_CLK,
  input wire logic       SRST,
  input wire logic       SCL_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OEN,
  input wire logic       BRIDGED_MONO_MODE,
  input wire logic       LEFT_STATE_HIZ,
  input wire logic       RIGHT_STATE_HIZ,
  input wire logic       LEFT_HIZ,
  input wire logic       RIGHT_HIZ,
  input wire logic [1:0] PROGRAM_SELECT,
  input wire logic       BUILTIN_COEF_SELECT,
  input wire logic [7:0] VOLUME_CODE,
  input wire logic       VOLUME_MUTE,
  input wire logic       VOLUME_BUSY
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  chk_left_state_pass: assert property (LEFT_STATE_HIZ |=> LEFT_HIZ)
    else $error("left state request lost");
  chk_right_state_pass: assert property (RIGHT_STATE_HIZ |=> RIGHT_HIZ)
    else $error("right state request lost");
  // Four cycles cover the two sync flops plus the output register
  chk_mono_left_off: assert property (
    (BRIDGED_MONO_MODE && !LEFT_STATE_HIZ) [*4] |-> !LEFT_HIZ)
    else $error("left forced in bridged mono");
  chk_mono_right_off: assert property (
    (BRIDGED_MONO_MODE && !RIGHT_STATE_HIZ) [*4] |-> !RIGHT_HIZ)
    else $error("right forced in bridged mono");
  chk_mute_decode: assert property (VOLUME_MUTE == (VOLUME_CODE == 8'hFF))
    else $error("mute flag disagrees with code");
  chk_reset_values: assert property ($fell(SRST) |->
    PROGRAM_SELECT == 2'h1 && BUILTIN_COEF_SELECT && VOLUME_CODE == 8'h30 && !VOLUME_BUSY)
    else $error("output reset values wrong");
  chk_idle_code_hold: assert property (!$past(VOLUME_BUSY) |-> $stable(VOLUME_CODE))
    else $error("code moved while on target");
  chk_sda_scl_high: assert property (SCL_I [*6] |-> $stable(SDA_OEN))
    else $error("data output moved while clock high");
  chk_sda_open_drain: assert property (SDA_O == 1'b0)
    else $error("data output not open drain");

  cover property ($rose(LEFT_HIZ));
  cover property ($rose(VOLUME_BUSY));
  cover property ($rose(VOLUME_MUTE));
  cover property (BRIDGED_MONO_MODE && !LEFT_HIZ);
endmodule

bind dmv_mode_volume dmv_mode_volume_sva u_dmv_mode_volume_sva (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OEN(SDA_OEN),
  .BRIDGED_MONO_MODE(BRIDGED_MONO_MODE), .LEFT_STATE_HIZ(LEFT_STATE_HIZ),
  .RIGHT_STATE_HIZ(RIGHT_STATE_HIZ), .LEFT_HIZ(LEFT_HIZ), .RIGHT_HIZ(RIGHT_HIZ),
  .PROGRAM_SELECT(PROGRAM_SELECT), .BUILTIN_COEF_SELECT(BUILTIN_COEF_SELECT),
  .VOLUME_CODE(VOLUME_CODE), .VOLUME_MUTE(VOLUME_MUTE), .VOLUME_BUSY(VOLUME_BUSY));
`default_nettype wire

/* verification/dmv_i2c_host.sv */
// Host model that reaches the registers over the serial control port
`timescale 1ns/1ps
`default_nettype none
`include "dmv_defs.vh"

module dmv_i2c_host (
  input  wire logic sys_clk,
  input  wire logic sda_o,
  input  wire logic sda_oen,
  output var  logic scl,
  output wire logic sda
);
  // ----
  // Wire and bit timing
  // ----
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  // Pull-up: the line reads high once every party lets go
  assign sda = sda_drv & (sda_oen | sda_o);
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Data only moves mid-low, so it never fakes a start or stop
  task automatic put_bit(input logic b, output logic r);
    hold(4);
    sda_drv = b;
    hold(4);
    scl = 1'b1;
    hold(4);
    r = sda;
    hold(4);
    scl = 1'b0;
  endtask
  task automatic start_cond();
    hold(4);
    sda_drv = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_drv = 1'b0;
    hold(8);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    hold(4);
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_drv = 1'b1;
    hold(8);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(b[i], r);
    put_bit(1'b1, r);
    ok = !r;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    put_byte({`DMV_I2C_DEVICE_ADDR, 1'b0}, k0);
    put_byte(a, k1);
    put_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, r;
    start_cond();
    put_byte({`DMV_I2C_DEVICE_ADDR, 1'b0}, k0);
    put_byte(a, k1);
    start_cond();
    put_byte({`DMV_I2C_DEVICE_ADDR, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(1'b1, r);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

/* verification/tb_dmv_mode_volume.sv */
// Self-checking bench of the mode and volume block
`timescale 1ns/1ps
`default_nettype none
`include "dmv_defs.vh"
`define CHECK(a, b, m) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: %s", $time, m); end end

module tb_dmv_mode_volume;
  // ----
  // Harness
  // ----
  logic       sys_clk;
  logic       srst = 1'b1;
  logic       frame_clk = 1'b0;
  logic       mono = 1'b0;
  logic       l_state = 1'b0;
  logic       r_state = 1'b0;
  logic [7:0] vol_exp = 8'h30;
  wire logic  scl, sda, sda_o, sda_oen, left_hiz, right_hiz, coef, mute, busy;
  wire logic [1:0] pgm, prate;
  wire logic [7:0] vol;
  int n_errors = 0;
  int n_tests = 0;

  dmv_mode_volume u_dmv_mode_volume (.SYS_CLK(sys_clk), .SRST(srst), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OEN(sda_oen), .FRAME_CLK(frame_clk),
    .BRIDGED_MONO_MODE(mono), .LEFT_STATE_HIZ(l_state), .RIGHT_STATE_HIZ(r_state),
    .LEFT_HIZ(left_hiz), .RIGHT_HIZ(right_hiz), .PROGRAM_SELECT(pgm),
    .BUILTIN_COEF_SELECT(coef), .PROCESSING_RATE(prate), .VOLUME_CODE(vol),
    .VOLUME_MUTE(mute), .VOLUME_BUSY(busy));
  dmv_i2c_host u_dmv_i2c_host (.sys_clk(sys_clk), .sda_o(sda_o), .sda_oen(sda_oen),
    .scl(scl), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_dmv_i2c_host.write_reg(a, d, ok);
    `CHECK(ok, 1'b1, "write not acknowledged")
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_dmv_i2c_host.read_reg(a, d, ok);
    `CHECK(ok, 1'b1, "read not acknowledged")
    `CHECK(d, e, "register read value")
  endtask
  // One sample period: sync needs about three cycles, so eight leave margin
  task automatic tick();
    frame_clk = 1'b1;
    settle(4);
    frame_clk = 1'b0;
    settle(4);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic test_reset();
    rd_chk(`DMV_OFS_PROGRAM_MODE_AND_HIZ, 8'h01);
    rd_chk(`DMV_OFS_PROCESSING_CONTROL, 8'h01);
    rd_chk(`DMV_OFS_DIGITAL_VOLUME, 8'h30);
    rd_chk(`DMV_OFS_VOLUME_RAMP_CONTROL, 8'h33);
    rd_chk(8'h41, 8'h00);
    `CHECK(vol, 8'h30, "reset volume")
    $display("test reset done");
  endtask
  task automatic test_hiz();
    wr(8'h40, 8'h09);
    `CHECK({left_hiz, right_hiz}, 2'b10, "left force")
    wr(8'h40, 8'h0D);
    `CHECK(right_hiz, 1'b1, "right force")
    wr(8'h46, 8'h01);
    wr(8'h4C, 8'h30);
    `CHECK({left_hiz, right_hiz}, 2'b11, "force dropped by other write")
    mono = 1'b1;
    settle(5);
    `CHECK({left_hiz, right_hiz}, 2'b00, "force in bridged mono")
    mono = 1'b0;
    settle(5);
    `CHECK({left_hiz, right_hiz}, 2'b11, "force lost after mono")
    wr(8'h40, 8'h05);
    `CHECK({left_hiz, right_hiz}, 2'b01, "left release")
    l_state = 1'b1;
    settle(3);
    `CHECK(left_hiz, 1'b1, "left follows state")
    l_state = 1'b0;
    wr(8'h40, 8'h01);
    r_state = 1'b1;
    settle(3);
    `CHECK({left_hiz, right_hiz}, 2'b01, "right follows state")
    r_state = 1'b0;
    settle(3);
    `CHECK(right_hiz, 1'b0, "right release")
    $display("test hiz done");
  endtask
  task automatic test_program();
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, 8'(i));
      `CHECK(pgm, 2'(i), "program select")
    end
    wr(8'h40, 8'h01);
    wr(8'h46, 8'h00);
    `CHECK(coef, 1'b0, "host coefficients")
    wr(8'h46, 8'hFF);
    `CHECK({coef, prate}, 3'b111, "rom coefficients")
    rd_chk(8'h46, 8'hF9);
    wr(8'h46, 8'h01);
    $display("test program done");
  endtask
  task automatic ramp(input logic [7:0] ctrl, input logic [7:0] tgt, input int div,
                      input logic [7:0] step);
    wr(`DMV_OFS_VOLUME_RAMP_CONTROL, ctrl);
    wr(`DMV_OFS_DIGITAL_VOLUME, tgt);
    `CHECK({busy, vol}, {1'b1, vol_exp}, "ramp start")
    for (int k = 1; k <= 64 && vol_exp != tgt; k++) begin
      tick();
      if (k % div == 0) begin
        if (tgt > vol_exp) vol_exp = (tgt - vol_exp > step) ? vol_exp + step : tgt;
        else vol_exp = (vol_exp - tgt > step) ? vol_exp - step : tgt;
      end
      `CHECK(vol, vol_exp, "ramp code")
    end
    `CHECK(busy, 1'b0, "busy after ramp")
    $display("test ramp %h to %h done", ctrl, tgt);
  endtask
  task automatic instant(input logic [7:0] ctrl, input logic [7:0] tgt);
    wr(`DMV_OFS_VOLUME_RAMP_CONTROL, ctrl);
    wr(`DMV_OFS_DIGITAL_VOLUME, tgt);
    vol_exp = tgt;
    `CHECK({busy, mute, vol}, {1'b0, tgt == 8'hFF, tgt}, "instant code")
    $display("test instant %h done", ctrl);
  endtask

  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    settle(2);
    test_reset();
    test_hiz();
    test_program();
    ramp(8'h00, 8'h3B, 1, 8'h08);
    ramp(8'h60, 8'h40, 2, 8'h02);
    ramp(8'h90, 8'h48, 4, 8'h04);
    ramp(8'h33, 8'h49, 1, 8'h01);
    ramp(8'h04, 8'h30, 2, 8'h08);
    ramp(8'h09, 8'h28, 4, 8'h04);
    ramp(8'h02, 8'h25, 1, 8'h02);
    ramp(8'h33, 8'h24, 1, 8'h01);
    instant(8'hC0, 8'hFF);
    instant(8'h0C, 8'h30);
    wrap_up();
  end
endmodule
`default_nettype wire
